/* rtl/phy_strap_ctrl_irq_enable_regs.sv */
// Strap status, expanded control and interrupt control/status registers,
// with the 10 Mbit/s preamble filter they steer.
// Assumes event pulses, speed and receive nibbles come from this clock domain;
// strap and management pins are asynchronous and are synchronised here.
`include "phy_regs_consts.svh"
`default_nettype none

// What this block does
// - MII back-to-back strap reads at bit 7
// - RMII back-to-back strap reads at bit 6
// - Pin-chain test strap reads at bit 5
// - RMII interface strap reads at bit 1
// - MII strap at bit 0; 4:2 read zero
// - Energy-detect power-down disable, resets to one
// - Receive latency select, random or fixed, writable on the MII variant only
// - 100 Mbit/s always forwards every preamble byte
// - Restore bit passes 10 Mbit/s preamble
// - Otherwise the MII variant strips preamble, frame starts one nibble before SFD
// - Jabber interrupt enable, resets to zero
// - Receive error interrupt enable, resets zero
// - Page received interrupt enable, resets zero
// - Parallel detect fault enable, resets zero
// - Link partner acknowledge enable, resets zero
// - Event flags set on event, clear on read
module phy_strap_ctrl_irq_enable_regs #(
    parameter logic [4:0] PHY_ADDR     = 5'h01,
    parameter bit         VARIANT_RMII = 1'b0
) (
    input  wire logic               clock,       // 20 MHz block clock
    input  wire logic               resetn,      // Async reset
    input  wire logic               mdc,         // Management clock pin
    input  wire logic               mdio_i,      // Management data in
    output var  logic               mdio_o,      // Management data out
    output var  logic               mdio_oe,     // Management data enable
    input  wire phy_pkg::strap_t    strap_pins,  // Configuration pins
    input  wire logic [7:0]         event_in,    // Event pulses, jabber at 7
    input  wire logic               speed_10,    // Link runs at 10 Mbit/s
    input  wire phy_pkg::nib_t      rx_in,       // Received nibble stream
    output var  phy_pkg::nib_t      rx_out,      // Nibbles toward MII
    output var  logic               intr,        // Interrupt, active high
    output var  logic               energy_detect_powerdown_off,    // Energy-detect power-down off
    output var  logic               rx_latency_random // Random receive latency
);

    phy_pkg::regs_st_t  s;
    phy_pkg::regs_st_t  n;
    phy_pkg::mgmt_req_t req;
    phy_pkg::strap_t    strap_mask;
    logic [15:0]        strap_word;
    logic [15:0]        exp_word;
    logic [15:0]        int_word;
    logic [15:0]        rd_word;
    logic               strip;

    // Serial management engine; it reads the word latched at the read pulse
    mdio_serial #(
        .PHY_ADDR (PHY_ADDR)
    ) u_mdio (
        .clock   (clock),
        .resetn  (resetn),
        .mdc     (mdc),
        .mdio_i  (mdio_i),
        .mdio_o  (mdio_o),
        .mdio_oe (mdio_oe),
        .req     (req),
        .rd_data (s.rdata)
    );

    // Straps of the other interface variant never show
    assign strap_mask.mii_b2b   = !VARIANT_RMII;
    assign strap_mask.rmii_b2b  = VARIANT_RMII;
    assign strap_mask.pin_chain = 1'h1;
    assign strap_mask.rmii_mode = VARIANT_RMII;
    assign strap_mask.mii_mode  = !VARIANT_RMII;

    // Register images as software sees them; reserved bits read zero
    always_comb begin
        strap_word = 16'h0000;
        strap_word[`STR_MII_B2B]  = s.strap.mii_b2b;
        strap_word[`STR_RMII_B2B] = s.strap.rmii_b2b;
        strap_word[`STR_CHAIN]    = s.strap.pin_chain;
        strap_word[`STR_RMII]     = s.strap.rmii_mode;
        strap_word[`STR_MII]      = s.strap.mii_mode;
        exp_word = 16'h0000;
        exp_word[`EXP_ENERGY_DETECT_POWERDOWN_BIT] = s.energy_detect_powerdown_dis;
        exp_word[`EXP_LAT_BIT]  = s.lat_rand;
        exp_word[`EXP_PRE_BIT]  = s.pre_restore;
        int_word = {s.ien, s.flags};
    end

    // Read decode; unmapped addresses read as zero
    always_comb begin
        if (req.addr == `REG_STRAP) begin
            rd_word = strap_word;
        end else if (req.addr == `REG_EXPCTL) begin
            rd_word = exp_word;
        end else if (req.addr == `REG_INTCS) begin
            rd_word = int_word;
        end else begin
            rd_word = 16'h0000;
        end
    end

    // Preamble stripping only applies at 10 Mbit/s on the MII variant
    assign strip = speed_10 & ~s.pre_restore & ~VARIANT_RMII;

    // Next-state logic for the whole block
    always_comb begin
        n = s;

        // Straps pass two flip-flops, settle, then freeze until reset
        n.strap_s1 = strap_pins;
        n.strap_s2 = s.strap_s1;
        if (!s.captured) begin
            if (s.settle == `STRAP_SETTLE) begin
                n.strap    = s.strap_s2 & strap_mask;
                n.captured = 1'h1;
            end else begin
                n.settle = s.settle + 2'h1;
            end
        end

        // Register writes; the strap register ignores them
        if (req.wr) begin
            if (req.addr == `REG_EXPCTL) begin
                n.energy_detect_powerdown_dis = req.wdata[`EXP_ENERGY_DETECT_POWERDOWN_BIT];
                if (!VARIANT_RMII) begin
                    n.lat_rand    = req.wdata[`EXP_LAT_BIT];
                    n.pre_restore = req.wdata[`EXP_PRE_BIT];
                end
            end else if (req.addr == `REG_INTCS) begin
                n.ien = req.wdata[15:8];
            end
        end

        // A read latches the image before its flags are cleared
        if (req.rd) begin
            n.rdata = rd_word;
        end

        // Clear on read of the interrupt register; a same-cycle event wins
        if (req.rd && req.addr == `REG_INTCS) begin
            n.flags = event_in;
        end else begin
            n.flags = s.flags | event_in;
        end

        // Interrupt follows the next flag and enable values
        n.intr = |(n.flags & n.ien);

        // Receive path advances one nibble per strobe, one stage of delay
        n.out.stb = 1'h0;
        if (rx_in.stb) begin
            n.d1      = rx_in;
            n.out     = s.d1;
            n.out.stb = 1'h1;
            if (s.in_pre) begin
                if (rx_in.dv && rx_in.nib == `SFD_NIB) begin
                    n.in_pre = 1'h0;
                end else begin
                    n.out.dv  = 1'h0;
                    n.out.nib = 4'h0;
                    n.in_pre  = rx_in.dv;
                end
            end
            if (!s.d1.dv && rx_in.dv) begin
                n.in_pre = strip;
            end
        end
    end

    // Whole-block state register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s          <= '0;
            s.energy_detect_powerdown_dis <= 1'((`EXPCTL_RST >> `EXP_ENERGY_DETECT_POWERDOWN_BIT) & 16'h0001);
            s.ien      <= `IEN_RST;
            s.flags    <= `FLAGS_RST;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from the state register
    assign rx_out            = s.out;
    assign intr              = s.intr;
    assign energy_detect_powerdown_off          = s.energy_detect_powerdown_dis;
    assign rx_latency_random = s.lat_rand;

    // Strap read returns the captured levels in their documented bits
    a_strap_read_bits: assert property (
        @(posedge clock) disable iff (!resetn)
        (req.rd && req.addr == `REG_STRAP)
        |=> (s.rdata[7] == $past(s.strap.mii_b2b))
            && (s.rdata[6] == $past(s.strap.rmii_b2b))
            && (s.rdata[5] == $past(s.strap.pin_chain))
            && (s.rdata[4:2] == 3'h0)
            && (s.rdata[1] == $past(s.strap.rmii_mode))
            && (s.rdata[0] == $past(s.strap.mii_mode)))
        else $error("strap read image wrong");

    // Once captured, the strap image never moves until reset
    a_strap_held: assert property (
        @(posedge clock) disable iff (!resetn)
        s.captured |=> s.captured && $stable(s.strap))
        else $error("strap image changed after capture");

    // Captured within the settle window after reset release
    a_strap_capture: assert property (
        @(posedge clock) disable iff (!resetn)
        $rose(s.settle == `STRAP_SETTLE) |=> s.captured)
        else $error("strap capture late");

    // Expanded control write lands in the control bits
    a_exp_write: assert property (
        @(posedge clock) disable iff (!resetn)
        (req.wr && req.addr == `REG_EXPCTL)
        |=> (energy_detect_powerdown_off == $past(req.wdata[11]))
            && (VARIANT_RMII || rx_latency_random == $past(req.wdata[10]))
            && (VARIANT_RMII || s.pre_restore == $past(req.wdata[6])))
        else $error("expanded control write lost");

    // Enable write lands in the upper half only
    a_enable_write: assert property (
        @(posedge clock) disable iff (!resetn)
        (req.wr && req.addr == `REG_INTCS)
        |=> (s.ien == $past(req.wdata[15:8]))
            && ((s.flags & ~$past(event_in)) == ($past(s.flags) & ~$past(event_in))))
        else $error("interrupt enable write wrong");

    // An event pulse always leaves its flag set, even during a clear
    a_flag_sticky: assert property (
        @(posedge clock) disable iff (!resetn)
        (|event_in) |=> (($past(event_in) & ~s.flags) == 8'h00))
        else $error("event flag not set");

    // A read of the register clears quiet flags and reports the old ones
    a_flag_clear: assert property (
        @(posedge clock) disable iff (!resetn)
        (req.rd && req.addr == `REG_INTCS && event_in == 8'h00)
        |=> (s.flags == 8'h00) && (s.rdata[7:0] == $past(s.flags)))
        else $error("read did not clear flags");

    // Interrupt matches enabled flags
    a_intr_level: assert property (
        @(posedge clock) disable iff (!resetn)
        intr == |(s.flags & s.ien))
        else $error("interrupt level mismatch");

    // Outside preamble stripping every nibble is forwarded one strobe later
    a_rx_forward: assert property (
        @(posedge clock) disable iff (!resetn)
        (rx_in.stb && !s.in_pre)
        |=> rx_out.stb && (rx_out.dv == $past(s.d1.dv))
            && (rx_out.nib == $past(s.d1.nib)))
        else $error("receive nibble not forwarded");

    // Preamble nibbles are held back, except the last one before the delimiter
    a_rx_strip: assert property (
        @(posedge clock) disable iff (!resetn)
        (rx_in.stb && s.in_pre && rx_in.nib != `SFD_NIB) |=> !rx_out.dv)
        else $error("preamble nibble leaked");

    // Stripping never starts at 100 Mbit/s or with restore set
    a_rx_nostrip: assert property (
        @(posedge clock) disable iff (!resetn)
        (rx_in.stb && rx_in.dv && !s.d1.dv && (!speed_10 || s.pre_restore))
        |=> !s.in_pre)
        else $error("stripping started wrongly");

endmodule
`default_nettype wire

/* rtl/phy_regs_consts.svh */
// Constants of the strap, expanded control and interrupt enable registers.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef PHY_REGS_CONSTS_SVH
`define PHY_REGS_CONSTS_SVH

// Register addresses on the management interface
`define REG_STRAP      5'h17
`define REG_EXPCTL     5'h18
`define REG_INTCS      5'h1B

// Expanded control field positions
`define EXP_ENERGY_DETECT_POWERDOWN_BIT   11
`define EXP_LAT_BIT    10
`define EXP_PRE_BIT    6

// Strap status field positions
`define STR_MII_B2B    7
`define STR_RMII_B2B   6
`define STR_CHAIN      5
`define STR_RMII       1
`define STR_MII        0

// Reset values
`define EXPCTL_RST     16'h0800
`define IEN_RST        8'h00
`define FLAGS_RST      8'h00

// Management frame timing, in management clock bits
`define PRE_LEN        6'h20
`define HDR_LAST       6'h0C
`define DATA_LAST      6'h0F
`define DATA_END       6'h10
`define OP_RD          2'h2
`define OP_WR          2'h1

// Receive nibble codes and strap settling, in clock cycles
`define PRE_NIB        4'h5
`define SFD_NIB        4'hD
`define STRAP_SETTLE   2'h2

`endif

/* rtl/phy_pkg.sv */
// Types shared by the management engine and the register block.
// Assumes the constants header is on the include path.
`default_nettype none
package phy_pkg;

    typedef struct packed {
        logic mii_b2b;
        logic rmii_b2b;
        logic pin_chain;
        logic rmii_mode;
        logic mii_mode;
    } strap_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } mgmt_req_t;

    typedef struct packed {
        logic       dv;
        logic       stb;
        logic [3:0] nib;
    } nib_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_HDR  = 4'h2,
        ST_TA   = 4'h4,
        ST_DATA = 4'h8
    } mdio_state_t;

    typedef struct packed {
        logic [1:0]  mdc_s;
        logic [1:0]  dio_s;
        logic        mdc_prev;
        mdio_state_t st;
        logic [5:0]  cnt;
        logic [15:0] sh;
        logic [4:0]  regad;
        logic        wr_op;
        logic        dout;
        logic        doe;
        mgmt_req_t   req;
    } mdio_st_t;

    typedef struct packed {
        strap_t      strap_s1;
        strap_t      strap_s2;
        logic [1:0]  settle;
        logic        captured;
        strap_t      strap;
        logic        energy_detect_powerdown_dis;
        logic        lat_rand;
        logic        pre_restore;
        logic [7:0]  ien;
        logic [7:0]  flags;
        logic [15:0] rdata;
        logic        intr;
        nib_t        d1;
        logic        in_pre;
        nib_t        out;
    } regs_st_t;

endpackage
`default_nettype wire

/* rtl/mdio_serial.sv */
// Serial management frame engine: preamble, header, turnaround, data.
// Assumes MDC high and low phases each last at least four clock cycles.
`include "phy_regs_consts.svh"
`default_nettype none
module mdio_serial #(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input  wire logic               clock,   // Block clock
    input  wire logic               resetn,  // Async reset
    input  wire logic               mdc,     // Management clock pin
    input  wire logic               mdio_i,  // Data pin level
    output var  logic               mdio_o,  // Data pin drive value
    output var  logic               mdio_oe, // Data pin drive enable
    output var  phy_pkg::mgmt_req_t req,     // Decoded access pulses
    input  wire logic [15:0]        rd_data  // Word captured for a read
);

    phy_pkg::mdio_st_t s;
    phy_pkg::mdio_st_t n;
    logic              rise;
    logic              fall;
    logic              bit_in;
    logic [12:0]       hdr;

    // Edges seen only on the second synchroniser stage
    assign rise   = s.mdc_s[1] & ~s.mdc_prev;
    assign fall   = ~s.mdc_s[1] & s.mdc_prev;
    assign bit_in = s.dio_s[1];
    assign hdr    = {s.sh[11:0], bit_in};

    assign mdio_o  = s.dout;
    assign mdio_oe = s.doe;
    assign req     = s.req;

    // Frame sequencing; reads drive after falling edges, writes sample rising
    always_comb begin
        n        = s;
        n.mdc_s  = {s.mdc_s[0], mdc};
        n.dio_s  = {s.dio_s[0], mdio_i};
        n.mdc_prev = s.mdc_s[1];
        n.req.rd = 1'h0;
        n.req.wr = 1'h0;
        case (s.st)
            phy_pkg::ST_IDLE: if (rise) begin
                if (bit_in) begin
                    if (s.cnt != `PRE_LEN) n.cnt = s.cnt + 6'h01;
                end else if (s.cnt == `PRE_LEN) begin
                    n.st  = phy_pkg::ST_HDR;
                    n.cnt = 6'h00;
                    n.sh  = 16'h0000;
                end else begin
                    n.cnt = 6'h00;
                end
            end
            phy_pkg::ST_HDR: if (rise) begin
                n.sh  = {s.sh[14:0], bit_in};
                n.cnt = s.cnt + 6'h01;
                if (s.cnt == `HDR_LAST) begin
                    n.cnt   = 6'h00;
                    n.regad = hdr[4:0];
                    n.st    = phy_pkg::ST_IDLE;
                    if (hdr[12] && hdr[9:5] == PHY_ADDR) begin
                        if (hdr[11:10] == `OP_RD) begin
                            n.st       = phy_pkg::ST_TA;
                            n.wr_op    = 1'h0;
                            n.req.rd   = 1'h1;
                            n.req.addr = hdr[4:0];
                        end else if (hdr[11:10] == `OP_WR) begin
                            n.st    = phy_pkg::ST_TA;
                            n.wr_op = 1'h1;
                        end
                    end
                end
            end
            phy_pkg::ST_TA: if (s.wr_op ? rise : fall) begin
                n.cnt = s.cnt + 6'h01;
                if (s.cnt != 6'h00) begin
                    n.st  = phy_pkg::ST_DATA;
                    n.cnt = 6'h00;
                    if (!s.wr_op) begin
                        n.doe = 1'h1;
                        n.dout = 1'h0;
                        n.sh  = rd_data;
                    end
                end
            end
            phy_pkg::ST_DATA: if (s.wr_op && rise) begin
                n.sh  = {s.sh[14:0], bit_in};
                n.cnt = s.cnt + 6'h01;
                if (s.cnt == `DATA_LAST) begin
                    n.req.wr    = 1'h1;
                    n.req.addr  = s.regad;
                    n.req.wdata = {s.sh[14:0], bit_in};
                    n.st  = phy_pkg::ST_IDLE;
                    n.cnt = 6'h00;
                end
            end else if (!s.wr_op && fall) begin
                if (s.cnt == `DATA_END) begin
                    n.doe = 1'h0;
                    n.st  = phy_pkg::ST_IDLE;
                    n.cnt = 6'h00;
                end else begin
                    n.dout = s.sh[15];
                    n.sh  = {s.sh[14:0], 1'h0};
                    n.cnt = s.cnt + 6'h01;
                end
            end
            default: n.st = phy_pkg::ST_IDLE;
        endcase
    end

    // Engine state register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s    <= '0;
            s.st <= phy_pkg::ST_IDLE;
        end else begin
            s <= n;
        end
    end

endmodule
`default_nettype wire

/* verif/mdio_master.sv */
// Station management controller model: clause-22 read and write frames.
// Assumes the data line is resolved outside with a pull-up; MDC halts between frames.
`default_nettype none
module mdio_master (
    input  wire logic clock,    // Block clock, paces MDC
    output var  logic mdc,      // Management clock
    output var  logic mdio_drv, // Data value we drive
    output var  logic mdio_en,  // High while we drive data
    input  wire logic mdio_line // Resolved data line
);
    timeunit 1ns;
    timeprecision 1ns;

    // Clock parked low and line released until a frame starts
    initial begin
        mdc = 1'b0;
        mdio_drv = 1'b0;
        mdio_en = 1'b0;
    end

    // One MDC period; five clocks a phase keeps both above the four-clock minimum
    task automatic bit_io(input logic en, input logic b, output logic s);
        mdc = 1'b0;
        mdio_en = en;
        mdio_drv = b;
        repeat (5) @(negedge clock);
        mdc = 1'b1;
        s = mdio_line;
        repeat (5) @(negedge clock);
    endtask

    // Whole frame; a wrong phy address is only sent when the bench asks for it
    task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rdv);
        logic [13:0] hdr;
        logic        s;
        hdr = {2'b01, rd, ~rd, phy, ra};
        for (int i = 0; i < 32; i++) bit_io(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) bit_io(1'b1, hdr[i], s);
        bit_io(~rd, 1'b1, s);
        bit_io(~rd, 1'b0, s);
        for (int i = 15; i >= 0; i--) begin
            bit_io(~rd, wd[i], s);
            rdv[i] = s;
        end
        // Final fall lets the device drop its drive; clock then stands still
        mdc = 1'b0;
        mdio_en = 1'b0;
        repeat (10) @(negedge clock);
    endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the strap, expanded control and interrupt registers.
// Assumes the management model in mdio_master and a pulled-up data line.
`include "phy_regs_consts.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic            clock, resetn, m_drv, m_en, dut_o, dut_oe, mdc;
    logic            speed_10, energy_detect_powerdown_off, lat_rnd, intr;
    logic [7:0]      event_in;
    logic [15:0]     rd;
    phy_pkg::strap_t strap_pins;
    phy_pkg::nib_t   rx_in, rx_out;
    wire logic       mdio_line;
    int              fail_count = 0;
    int              n_tests = 0;

    // Line resolution: device, then controller, else the pull-up
    assign mdio_line = dut_oe ? dut_o : (m_en ? m_drv : 1'b1);

    phy_strap_ctrl_irq_enable_regs dut (
        .clock(clock), .resetn(resetn), .mdc(mdc), .mdio_i(mdio_line), .mdio_o(dut_o),
        .mdio_oe(dut_oe), .strap_pins(strap_pins), .event_in(event_in), .speed_10(speed_10),
        .rx_in(rx_in), .rx_out(rx_out), .intr(intr), .energy_detect_powerdown_off(energy_detect_powerdown_off),
        .rx_latency_random(lat_rnd)
    );

    mdio_master mgr (
        .clock(clock), .mdc(mdc), .mdio_drv(m_drv), .mdio_en(m_en), .mdio_line(mdio_line)
    );

    // 50 ns period
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic final_report();
        if (fail_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rreg(input logic [4:0] a, input logic [15:0] exp);
        mgr.frame(1'b1, 5'h01, a, 16'h0000, rd);
        chk(rd, exp);
    endtask

    task automatic wreg(input logic [4:0] a, input logic [15:0] d);
        mgr.frame(1'b0, 5'h01, a, d, rd);
    endtask

    // Strap pins stay put through the settle window after release
    task automatic do_reset(input phy_pkg::strap_t s);
        strap_pins = s;
        resetn = 1'b0;
        repeat (10) @(negedge clock);
        resetn = 1'b1;
        repeat (6) @(negedge clock);
    endtask

    task automatic pulse(input logic [7:0] e);
        event_in = e;
        @(negedge clock);
        event_in = 8'h00;
        repeat (2) @(negedge clock);
    endtask

    // Fifteen preamble nibbles, SFD, two data nibbles; each output lags one strobe
    task automatic rx_run(input logic strip);
        logic [3:0] prev;
        logic [3:0] n;
        int         w;
        prev = 4'h0;
        rx_in.dv = 1'b1;
        for (int k = 0; k < 18; k++) begin
            n = (k < 15) ? 4'h5 : (k == 15) ? 4'hD : (k == 16) ? 4'hA : 4'h3;
            rx_in.nib = n;
            rx_in.stb = 1'b1;
            @(negedge clock);
            rx_in.stb = 1'b0;
            w = 0;
            while (rx_out.stb !== 1'b1 && w < 4) begin
                @(negedge clock);
                w++;
            end
            if (w == 4) begin
                fail_count++;
                final_report();
            end
            if (k > 0 || strip) chk({11'h000, rx_out.dv, rx_out.nib},
                (strip && k < 15) ? 16'h0000 : {12'h001, prev});
            prev = n;
            // Strobe stays low across one edge before the next one rises
            @(negedge clock);
        end
        rx_in = '0;
        repeat (4) @(negedge clock);
    endtask

    initial begin
        resetn = 1'b0;
        event_in = 8'h00;
        speed_10 = 1'b0;
        rx_in = '0;
        strap_pins = '0;
        do_reset(5'h1F);
        chk({15'h0000, energy_detect_powerdown_off}, 16'h0001);
        chk({15'h0000, lat_rnd}, 16'h0000);
        rreg(`REG_STRAP, 16'h00A1);
        strap_pins = 5'h00;
        rreg(`REG_STRAP, 16'h00A1);
        wreg(`REG_STRAP, 16'hFFFF);
        rreg(`REG_STRAP, 16'h00A1);
        rreg(`REG_EXPCTL, 16'h0800);
        rreg(`REG_INTCS, 16'h0000);
        rreg(5'h10, 16'h0000);
        speed_10 = 1'b1;
        rx_run(1'b1);
        speed_10 = 1'b0;
        rx_run(1'b0);
        wreg(`REG_EXPCTL, 16'hFFFF);
        rreg(`REG_EXPCTL, 16'h0C40);
        chk({15'h0000, energy_detect_powerdown_off}, 16'h0001);
        chk({15'h0000, lat_rnd}, 16'h0001);
        speed_10 = 1'b1;
        rx_run(1'b0);
        // Frame for another station must leave the register alone
        mgr.frame(1'b0, 5'h02, `REG_EXPCTL, 16'h0000, rd);
        rreg(`REG_EXPCTL, 16'h0C40);
        wreg(`REG_EXPCTL, 16'h0000);
        rreg(`REG_EXPCTL, 16'h0000);
        chk({15'h0000, energy_detect_powerdown_off}, 16'h0000);
        chk({15'h0000, lat_rnd}, 16'h0000);
        // Each enable alone: a neighbour's event must not interrupt
        for (int i = 0; i < 8; i++) begin
            wreg(`REG_INTCS, 16'h0100 << i);
            pulse(8'h01 << ((i + 1) % 8));
            chk({15'h0000, intr}, 16'h0000);
            pulse(8'h01 << i);
            chk({15'h0000, intr}, 16'h0001);
            rreg(`REG_INTCS, (16'h0101 << i) | (16'h0001 << ((i + 1) % 8)));
            chk({15'h0000, intr}, 16'h0000);
            rreg(`REG_INTCS, 16'h0100 << i);
        end
        do_reset(5'h00);
        rreg(`REG_STRAP, 16'h0000);
        rreg(`REG_INTCS, 16'h0000);
        rreg(`REG_EXPCTL, 16'h0800);
        final_report();
    end
endmodule
`default_nettype wire
